// ---- design/rcm_pkg.sv ----
/*
 * Constants, types and register map of the reset command decoder.
 * Assumes one 40 MHz clock and a 16-bit command word from the host.
 */
package rcm_pkg;

    // ------------------------------------------------------------
    // Command word
    // ------------------------------------------------------------
    localparam int unsigned CMD_W    = 16;
    localparam int unsigned CODE_LSB = 11;
    localparam logic [4:0]  CODE_FULL = 5'h00;
    localparam logic [4:0]  CODE_RX   = 5'h05;
    localparam logic [31:0] UNUSED_SET = 32'hF414_0000; // One bit per code

    // ------------------------------------------------------------
    // Parameter bit positions
    // ------------------------------------------------------------
    localparam int unsigned P_XCVR = 0;
    localparam int unsigned P_CODEC = 1;
    localparam int unsigned P_MAC = 2;
    localparam int unsigned P_QUEUE = 3;
    localparam int unsigned P_AUTO = 4;
    localparam int unsigned P_BUS = 5;
    localparam int unsigned P_MGMT = 6;
    localparam int unsigned P_OSC = 7;
    localparam int unsigned P_DMA = 8;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_ISTAT = 8'h04;
    localparam logic [7:0] A_IMASK = 8'h08;
    localparam logic [7:0] A_INDM  = 8'h0C;
    localparam logic [7:0] A_INFO  = 8'h10;
    localparam int unsigned ST_PEND = 12;
    localparam int unsigned IN_UNUSED = 5;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned FULL_RST_NS   = 1_000_000; // 1 ms worst case
    localparam int unsigned FULL_RST_CYC  = FULL_RST_NS / CLK_PERIOD_NS;
    localparam int unsigned QUICK_CYC     = 16;
    localparam int unsigned RX_CYC        = 8;
    localparam logic [15:0] CNT_ONE       = 16'h0001;

    typedef enum logic [1:0] {RCM_IDLE, RCM_FULL, RCM_RX} rcm_state_e;

    // Full reset lines to each sub-unit, high while held in reset
    typedef struct packed {
        logic xcvr;
        logic codec;
        logic mac_core;
        logic queue_ctrl;
        logic autoinit;
        logic bus_iface;
        logic mgmt_serial;
        logic oscillator;
        logic dma_engines;
        logic eeprom_reload;
        logic cfg_alias_clr;
    } rcm_full_s;

    // Receive reset lines and their side effects
    typedef struct packed {
        logic rx_xcvr;
        logic rx_codec;
        logic rx_mac;
        logic rx_filter_clr;
        logic rx_queue;
        logic rx_thresh_off;
        logic upload;
    } rcm_rx_s;

endpackage

// ---- design/rcm_top.sv ----
/*
 * Reset command decoder: takes command words, runs full and receive
 * resets with per-unit exemption masks, and shows the pending flag.
 * Assumes a synchronous master on the register port that never issues
 * both strobes at once; sub-units sample the reset lines on mclk.
 */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module rcm_top
    import rcm_pkg::*;
#(
    parameter int unsigned FULL_CYC = rcm_pkg::FULL_RST_CYC
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          addr,
    input  wire logic [15:0]         wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic [15:0]              rdata,
    output logic                     command_pending_flag,
    output rcm_pkg::rcm_full_s       full_rst,
    output rcm_pkg::rcm_rx_s         rx_rst
);
    import rcm_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_unused(input logic [4:0] code);
        is_unused = UNUSED_SET[code];
    endfunction

    function automatic logic [4:0] code_of(input logic [15:0] w);
        code_of = w[CODE_LSB +: 5];
    endfunction

    localparam logic [15:0] FULL_N = FULL_CYC[15:0];
    localparam logic [15:0] QUICK_N = QUICK_CYC[15:0];
    localparam logic [15:0] RX_N = RX_CYC[15:0];

    rcm_state_e   state_q;
    logic [15:0]  cnt_q;
    logic [8:0]   keep_q;
    logic [15:0]  imask_q;
    logic [15:0]  indm_q;
    logic [15:0]  last_q;
    logic         unused_q;
    logic         cmd_wr;
    logic         acc_full;
    logic         acc_rx;
    logic         acc_unused;
    logic         bus_clr;

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    // Words arriving while busy are dropped; software must poll first
    assign cmd_wr = wr_en && (addr == A_CMD) && (state_q == RCM_IDLE);
    assign acc_full = cmd_wr && (code_of(wdata) == CODE_FULL);
    assign acc_rx = cmd_wr && (code_of(wdata) == CODE_RX);
    assign acc_unused = cmd_wr && is_unused(code_of(wdata));
    // Bus interface registers clear at the first cycle of a full reset whose bus keep bit is clear
    assign bus_clr = acc_full && !wdata[P_BUS];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Reload from EEPROM needs the long wait; otherwise a short one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= RCM_IDLE;
            cnt_q   <= ZERO16;
            keep_q  <= 9'h000;
        end else begin
            case (state_q)
                RCM_IDLE: begin
                    if (acc_full) begin
                        state_q <= RCM_FULL;
                        keep_q  <= wdata[P_DMA:0];
                        cnt_q   <= wdata[P_AUTO] ? QUICK_N : FULL_N;
                    end else if (acc_rx) begin
                        state_q <= RCM_RX;
                        keep_q  <= wdata[P_DMA:0];
                        cnt_q   <= RX_N;
                    end
                end
                RCM_FULL, RCM_RX: begin
                    if (cnt_q == CNT_ONE) begin
                        state_q <= RCM_IDLE;
                    end
                    cnt_q <= cnt_q - CNT_ONE;
                end
                default: begin
                    state_q <= RCM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pending flag
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            command_pending_flag <= 1'b0;
        end else begin
            command_pending_flag <= acc_full || acc_rx ||
                ((state_q != RCM_IDLE) && (cnt_q != CNT_ONE));
        end
    end

    // ------------------------------------------------------------
    // Full reset lines, each masked by a keep bit except cfg_alias_clr, which is always set
    // ------------------------------------------------------------
    // Registered so sub-units never see a decode glitch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            full_rst <= '0;
        end else if (acc_full) begin
            full_rst.xcvr        <= !wdata[P_XCVR];
            full_rst.codec       <= !wdata[P_CODEC];
            full_rst.mac_core    <= !wdata[P_MAC];
            full_rst.queue_ctrl  <= !wdata[P_QUEUE];
            full_rst.autoinit    <= !wdata[P_AUTO];
            full_rst.eeprom_reload <= !wdata[P_AUTO];
            full_rst.bus_iface   <= !wdata[P_BUS];
            full_rst.mgmt_serial <= !wdata[P_MGMT];
            full_rst.oscillator  <= !wdata[P_OSC];
            full_rst.dma_engines <= !wdata[P_DMA];
            full_rst.cfg_alias_clr <= 1'b1;
        end else if (state_q == RCM_FULL && cnt_q == CNT_ONE) begin
            full_rst <= '0;
        end
    end

    // ------------------------------------------------------------
    // Receive reset lines
    // ------------------------------------------------------------
    // Transmit side is never touched by this command
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_rst <= '0;
        end else if (acc_rx) begin
            rx_rst.rx_xcvr       <= !wdata[P_XCVR];
            rx_rst.rx_codec      <= !wdata[P_CODEC];
            rx_rst.rx_mac        <= !wdata[P_MAC];
            rx_rst.rx_filter_clr <= !wdata[P_MAC];
            rx_rst.rx_queue      <= !wdata[P_QUEUE];
            rx_rst.rx_thresh_off <= !wdata[P_QUEUE];
            rx_rst.upload        <= !wdata[P_DMA];
        end else if (state_q == RCM_RX && cnt_q == CNT_ONE) begin
            rx_rst <= '0;
        end
    end

    // ------------------------------------------------------------
    // Mask registers, cleared by an unexempted full reset
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst || bus_clr) begin
            imask_q <= ZERO16;
            indm_q  <= ZERO16;
        end else begin
            if (wr_en && addr == A_IMASK) begin
                imask_q <= wdata;
            end
            if (wr_en && addr == A_INDM) begin
                indm_q <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Last command and unused-code flag
    // ------------------------------------------------------------
    // Unused codes leave only this flag and the last command word; nothing else moves
    always_ff @(posedge mclk) begin
        if (sys_rst || bus_clr) begin
            unused_q <= 1'b0;
        end else if (acc_unused) begin
            unused_q <= 1'b1;
        end else if (rd_en && addr == A_INFO) begin
            unused_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            last_q <= ZERO16;
        end else if (cmd_wr) begin
            last_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Read port, data valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= ZERO16;
        end else if (rd_en) begin
            case (addr)
                A_ISTAT: begin
                    rdata <= ZERO16;
                    rdata[ST_PEND] <= command_pending_flag;
                end
                A_IMASK: begin
                    rdata <= imask_q;
                end
                A_INDM: begin
                    rdata <= indm_q;
                end
                A_INFO: begin
                    rdata <= {last_q[15:IN_UNUSED+1], unused_q,
                              last_q[IN_UNUSED-1:0]};
                end
                default: begin
                    rdata <= ZERO16;
                end
            endcase
        end else begin
            rdata <= ZERO16;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_unused_no_op: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_unused |=> !command_pending_flag && full_rst == '0 && rx_rst == '0)
        else $error("unused code started an operation");

    chk_full_pend_set: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> command_pending_flag && full_rst.cfg_alias_clr)
        else $error("full reset did not raise pending");

    chk_keep_xcvr: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.xcvr == !$past(wdata[P_XCVR]))
        else $error("transceiver keep bit ignored");

    chk_keep_dma: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.dma_engines == !$past(wdata[P_DMA]))
        else $error("dma keep bit ignored");

    chk_reload_long: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full && !wdata[P_AUTO] |=> command_pending_flag[*8])
        else $error("reload reset ended early");

    chk_bus_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full && !wdata[P_BUS] |=> imask_q == ZERO16 && indm_q == ZERO16)
        else $error("mask registers not cleared");

    chk_rx_filter: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx && !wdata[P_MAC] |=> rx_rst.rx_filter_clr && rx_rst.rx_mac)
        else $error("receive filter not cleared");

    chk_rx_upload: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx && wdata[P_DMA] |=> !rx_rst.upload)
        else $error("upload reset despite keep bit");

    chk_rx_length: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx |=> command_pending_flag[*8] ##1 !command_pending_flag)
        else $error("receive reset length wrong");

    chk_pend_read: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_en && addr == A_ISTAT |=> rdata[ST_PEND] == $past(command_pending_flag))
        else $error("pending flag read back wrong");

    chk_keep_codec: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.codec == !$past(wdata[P_CODEC]))
        else $error("codec keep bit ignored");

    chk_keep_mac: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.mac_core == !$past(wdata[P_MAC]))
        else $error("mac core keep bit ignored");

    chk_keep_queue: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.queue_ctrl == !$past(wdata[P_QUEUE]))
        else $error("queue keep bit ignored");

    // Reload request must follow the auto-init line exactly
    chk_keep_autoinit: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.autoinit == !$past(wdata[P_AUTO]) &&
            full_rst.eeprom_reload == !$past(wdata[P_AUTO]))
        else $error("auto-init keep bit ignored");

    chk_keep_bus: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.bus_iface == !$past(wdata[P_BUS]))
        else $error("bus interface keep bit ignored");

    chk_keep_mgmt: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.mgmt_serial == !$past(wdata[P_MGMT]))
        else $error("management keep bit ignored");

    chk_keep_osc: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full |=> full_rst.oscillator == !$past(wdata[P_OSC]))
        else $error("oscillator keep bit ignored");

    chk_alias_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == RCM_FULL |-> full_rst.cfg_alias_clr)
        else $error("alias registers not cleared");

    // Transceiver and DMA lines must not drift from the latched keep mask while a full reset runs
    chk_full_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == RCM_FULL |-> full_rst.xcvr == !keep_q[P_XCVR] &&
            full_rst.dma_engines == !keep_q[P_DMA])
        else $error("full reset lines changed mid-run");

    chk_rx_keep_xcvr: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx |=> rx_rst.rx_xcvr == !$past(wdata[P_XCVR]))
        else $error("receive transceiver keep bit ignored");

    chk_rx_keep_codec: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx |=> rx_rst.rx_codec == !$past(wdata[P_CODEC]))
        else $error("receive codec keep bit ignored");

    chk_rx_queue: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_rx |=> rx_rst.rx_queue == !$past(wdata[P_QUEUE]) &&
            rx_rst.rx_thresh_off == !$past(wdata[P_QUEUE]))
        else $error("receive queue keep bit ignored");

    chk_rx_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == RCM_RX |-> rx_rst.upload == !keep_q[P_DMA])
        else $error("upload line changed mid-run");

    chk_rx_no_full: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == RCM_RX |-> full_rst == '0)
        else $error("receive reset touched full reset lines");

    chk_pend_state: assert property (@(posedge mclk) disable iff (sys_rst)
        command_pending_flag == (state_q != RCM_IDLE))
        else $error("pending flag out of step with sequencer");

    chk_quick_length: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_full && wdata[P_AUTO] |=> ##15 command_pending_flag ##1 !command_pending_flag)
        else $error("quick full reset length wrong");

    // A command written while busy must not restart the countdown
    chk_busy_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == A_CMD && state_q != RCM_IDLE |=> cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("command accepted while busy");

    chk_unused_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_unused |=> unused_q)
        else $error("unused code left no trace");

endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
/*
 * Self-checking bench of the reset command decoder: register access,
 * full and receive resets with random keep masks, unused codes, drops.
 * Assumes rcm_top with a shortened full reset and the package map.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import rcm_pkg::*;
    // ------------------------------------------------------------
    // Clock, reset and design
    // ------------------------------------------------------------
    localparam int unsigned FULL_SIM = 20; // Short stand-in for 1 ms
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] rdata;
    logic        command_pending_flag;
    rcm_full_s   full_rst;
    rcm_rx_s     rx_rst;
    int unsigned n_errors = 0;
    int unsigned checks_done = 0;
    int unsigned cycles = 0;
    logic [15:0] lfsr_q = 16'h0B35; // Seed 2869
    logic [15:0] d;
    logic [15:0] m;
    logic [8:0]  p;
    logic [4:0]  unused_codes [7] = '{5'h12, 5'h14, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};

    rcm_top #(.FULL_CYC(FULL_SIM)) u_rcm_top (
        .mclk                 (mclk),
        .sys_rst              (sys_rst),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rdata                (rdata),
        .command_pending_flag (command_pending_flag),
        .full_rst             (full_rst),
        .rx_rst               (rx_rst)
    );

    // Free running clock, 25 ns period
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Keep bit set means that line stays low
    function automatic logic [15:0] exp_full(input logic [8:0] k);
        return {5'h00, ~k[0], ~k[1], ~k[2], ~k[3], ~k[4], ~k[5], ~k[6], ~k[7], ~k[8], ~k[4], 1'b1};
    endfunction

    function automatic logic [15:0] exp_rx(input logic [8:0] k);
        return {9'h000, ~k[0], ~k[1], ~k[2], ~k[2], ~k[3], ~k[3], ~k[8]};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask

    // Issue a command, follow the lines while pending, time it
    task automatic run_cmd(input logic [15:0] w, input logic [15:0] lines,
                           input int unsigned cyc, input logic is_rx);
        int unsigned n;
        wr(A_CMD, w);
        #1 n = 0;
        while (command_pending_flag === 1'b1 && n < 1000) begin
            check(is_rx ? {9'h000, rx_rst} : {5'h00, full_rst}, lines);
            @(posedge mclk);
            #1 n = n + 1;
        end
        check(n[15:0], cyc[15:0]);
        check({5'h00, full_rst}, ZERO16);
        check({9'h000, rx_rst}, ZERO16);
    endtask

    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 check({4'h0, command_pending_flag, full_rst}, ZERO16);
        check({9'h000, rx_rst}, ZERO16);
        rd(8'h40, d);
        check(d, ZERO16);
        $display("Test reset and unmapped done");

        // Full resets: no keeps, all keeps, then random masks
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            p = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : lfsr_q[8:0];
            m = lfsr_q | 16'h0001;
            wr(A_IMASK, m);
            wr(A_INDM, ~m);
            run_cmd({7'h00, p}, exp_full(p), p[4] ? QUICK_CYC : FULL_SIM, 1'b0);
            rd(A_IMASK, d);
            check(d, p[5] ? m : ZERO16);
            rd(A_INDM, d);
            check(d, p[5] ? ~m : ZERO16);
        end
        $display("Test full reset done");

        // Receive resets, parameter bits outside the mask random too
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            p = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : lfsr_q[8:0];
            run_cmd({5'h05, lfsr_q[15:14], p[8], lfsr_q[13:10], p[3:0]},
                    exp_rx(p), RX_CYC, 1'b1);
        end
        $display("Test receive reset done");

        // A command while pending is dropped; status shows pending
        wr(A_CMD, 16'h2800);
        rd(A_ISTAT, d);
        check({15'h0000, d[ST_PEND]}, 16'h0001);
        wr(A_CMD, 16'h0000);
        for (int n = 0; n < 20 && command_pending_flag === 1'b1; n++) begin
            @(posedge mclk);
        end
        @(posedge mclk);
        #1 check({4'h0, command_pending_flag, full_rst}, ZERO16);
        $display("Test drop done");

        // Unused codes: no action, sticky flag, cleared by read
        for (int i = 0; i < 7; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(A_CMD, {unused_codes[i], lfsr_q[10:0]});
            #1 check({4'h0, command_pending_flag, full_rst}, ZERO16);
            check({9'h000, rx_rst}, ZERO16);
            rd(A_INFO, d);
            check(d, {unused_codes[i], lfsr_q[10:6], 1'b1, lfsr_q[4:0]});
            rd(A_INFO, d);
            check(d, {unused_codes[i], lfsr_q[10:6], 1'b0, lfsr_q[4:0]});
        end
        wr(A_CMD, 16'h0800);
        #1 check({15'h0000, command_pending_flag}, ZERO16);
        rd(A_INFO, d);
        check(d, 16'h0800);
        $display("Test unused codes done");
        final_report();
    end
endmodule

`default_nettype wire
